/* File: self_cal_correct.sv */
// Self-calibration register bank and offset/gain correction path
`timescale 1ns/1ns
`default_nettype none
`include "self_cal_cfg.svh"
module self_cal_correct
  #(parameter int DATA_W = `CAL_WIDTH)
  (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  input  wire logic              cal_busy_i,
  input  wire logic              cal_load_i,
  input  wire logic [DATA_W-1:0] cal_offset_i,
  input  wire logic [DATA_W-1:0] cal_gain_i,
  input  wire logic              unipolar_i,
  input  wire logic              raw_valid_i,
  input  wire logic [DATA_W-1:0] raw_data_i,
  output logic                   out_valid_o,
  output logic [DATA_W-1:0]      out_data_o,
  output logic                   out_unipolar_o
  );
  localparam int EXT_W  = DATA_W + 2;
  localparam int PROD_W = EXT_W + DATA_W;
  localparam logic signed [EXT_W-1:0] MAX_CODE = EXT_W'({1'b0, {(DATA_W-1){1'b1}}});
  localparam logic signed [EXT_W-1:0] MIN_CODE = -MAX_CODE - EXT_W'(1);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (DATA_W != `CAL_WIDTH)
  begin : g_width_check
    $error("self_cal_correct: DATA_W must equal the calibration register width");
  end
  if (`CAL_GAIN_FRAC_BITS != DATA_W - 2)
  begin : g_gain_format_check
    $error("self_cal_correct: gain format needs two integer bits");
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  logic [DATA_W-1:0] self_cal_offset_reg;
  logic [DATA_W-1:0] self_cal_gain_reg;
  logic [1:0]        control_three_reg;
  logic [`SPI_ADDR_BITS-1:0] addr;
  logic              wr;
  logic [DATA_W-1:0] wr_data;
  wire               offset_correction_disable = control_three_reg[`CTRL_OFF_DIS_BIT];
  wire               gain_correction_disable   = control_three_reg[`CTRL_GAIN_DIS_BIT];
  wire               wr_offset = wr && (addr == `REG_IDX_OFFSET);
  wire               wr_gain   = wr && (addr == `REG_IDX_GAIN) && !cal_busy_i;
  wire               wr_ctrl   = wr && (addr == `REG_IDX_CTRL);
  wire [DATA_W-1:0]  rd_data =
    (addr == `REG_IDX_OFFSET) ? self_cal_offset_reg :
    (addr == `REG_IDX_GAIN)   ? self_cal_gain_reg :
    (addr == `REG_IDX_CTRL)   ? {{(DATA_W-2){1'b0}}, control_three_reg} : '0;
  // Index three reads as zero; writes to it match no decode and are lost
  // A self-calibration result wins over a software write in the same cycle
  wire [DATA_W-1:0]  self_cal_offset_next =
    cal_load_i ? cal_offset_i :
    wr_offset  ? wr_data : self_cal_offset_reg;
  wire [DATA_W-1:0]  self_cal_gain_next =
    cal_load_i ? cal_gain_i :
    wr_gain    ? wr_data : self_cal_gain_reg;
  wire [1:0]         control_three_next =
    wr_ctrl ? wr_data[`CTRL_GAIN_DIS_BIT:`CTRL_OFF_DIS_BIT] : control_three_reg;

  cal_serial_port #(.DATA_W(DATA_W)) u_cal_serial_port
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .cs_n_i     (cs_n_i),
    .sclk_i     (sclk_i),
    .sdi_i      (sdi_i),
    .sdo_o      (sdo_o),
    .addr_o     (addr),
    .rd_start_o (),
    .rd_data_i  (rd_data),
    .wr_o       (wr),
    .wr_data_o  (wr_data)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      self_cal_offset_reg <= `CAL_OFFSET_RESET;
      self_cal_gain_reg   <= `CAL_GAIN_RESET;
      control_three_reg   <= `CTRL_RESET;
    end
    else
    begin
      self_cal_offset_reg <= self_cal_offset_next;
      self_cal_gain_reg   <= self_cal_gain_next;
      control_three_reg   <= control_three_next;
    end
  end

  // ****************************************************************
  // Offset and gain arithmetic
  // ****************************************************************
  // Two guard bits keep the offset difference exact before it saturates
  self_cal_pkg::corr_state_t state_reg;
  logic signed [EXT_W-1:0]  acc_reg;
  logic                     uni_reg;
  wire signed [EXT_W-1:0]   raw_ext = EXT_W'(signed'(raw_data_i));
  wire signed [EXT_W-1:0]   off_ext = EXT_W'(signed'(self_cal_offset_reg));
  wire signed [EXT_W-1:0]   off_sub = raw_ext - off_ext;
  wire signed [EXT_W-1:0]   off_res = offset_correction_disable ? raw_ext : off_sub;
  wire signed [EXT_W-1:0]   off_sat = (off_res > MAX_CODE) ? MAX_CODE :
                                      (off_res < MIN_CODE) ? MIN_CODE : off_res;
  // Gain is Q2.22: 0x400000 is unity, 0x7FFFFF is just under two
  wire signed [PROD_W-1:0]  prod = acc_reg * PROD_W'(signed'(self_cal_gain_reg));
  wire signed [PROD_W-1:0]  prod_rnd = prod + PROD_W'(1 << (`CAL_GAIN_FRAC_BITS - 1));
  wire signed [PROD_W-1:0]  prod_sh = prod_rnd >>> `CAL_GAIN_FRAC_BITS;
  wire signed [PROD_W-1:0]  max_w = PROD_W'(MAX_CODE);
  wire signed [PROD_W-1:0]  min_w = PROD_W'(MIN_CODE);
  wire signed [EXT_W-1:0]   gain_sat = (prod_sh > max_w) ? MAX_CODE :
                                       (prod_sh < min_w) ? MIN_CODE :
                                       EXT_W'(prod_sh);
  wire signed [EXT_W-1:0]   gain_res = gain_correction_disable ? acc_reg : gain_sat;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  self_cal_pkg::corr_state_t state_next;
  logic signed [EXT_W-1:0]  acc_next;
  logic                     uni_next;
  logic                     out_valid_next;
  logic [DATA_W-1:0]        out_data_next;
  logic                     out_unipolar_next;

  // One sample in flight; samples that arrive while busy are dropped
  always_comb
  begin
    state_next        = state_reg;
    acc_next          = acc_reg;
    uni_next          = uni_reg;
    out_valid_next    = 1'b0;
    out_data_next     = out_data_o;
    out_unipolar_next = out_unipolar_o;
    case (state_reg)
      self_cal_pkg::ST_IDLE:
      begin
        if (raw_valid_i)
        begin
          acc_next   = off_sat;
          uni_next   = unipolar_i;
          state_next = self_cal_pkg::ST_GAIN;
        end
      end
      self_cal_pkg::ST_GAIN:
      begin
        acc_next   = gain_res;
        state_next = self_cal_pkg::ST_DONE;
      end
      self_cal_pkg::ST_DONE:
      begin
        out_valid_next    = 1'b1;
        out_data_next     = acc_reg[DATA_W-1:0];
        out_unipolar_next = uni_reg;
        state_next        = self_cal_pkg::ST_IDLE;
      end
      default:
        state_next = self_cal_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= self_cal_pkg::ST_IDLE;
      acc_reg   <= '0;
      uni_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      uni_reg   <= uni_next;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Each result holds on the outputs until the next one replaces it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_valid_o    <= 1'b0;
      out_data_o     <= '0;
      out_unipolar_o <= 1'b0;
    end
    else
    begin
      out_valid_o    <= out_valid_next;
      out_data_o     <= out_data_next;
      out_unipolar_o <= out_unipolar_next;
    end
  end
endmodule
`default_nettype wire

/* File: self_cal_cfg.svh */
// Constants for the self-calibration offset and gain correction block
`ifndef SELF_CAL_CFG_SVH
`define SELF_CAL_CFG_SVH
`define CAL_WIDTH          24
`define CAL_OFFSET_RESET   24'h000000
`define CAL_GAIN_RESET     24'h400000
`define CAL_GAIN_FRAC_BITS 22
`define SPI_ADDR_BITS      2
`define SPI_FRAME_BITS     32
`define REG_IDX_OFFSET     2'h0
`define REG_IDX_GAIN       2'h1
`define REG_IDX_CTRL       2'h2
`define CTRL_OFF_DIS_BIT   0
`define CTRL_GAIN_DIS_BIT  1
`define CTRL_RESET         2'h0
`define SPI_CMD_BITS       8
`define SPI_CMD_RD_BIT     7
`endif

/* File: self_cal_pkg.sv */
// Types for the self-calibration offset and gain correction block
`default_nettype none
package self_cal_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_OFFSET, ST_GAIN, ST_DONE} corr_state_t;
endpackage
`default_nettype wire

/* File: cal_serial_port.sv */
// Serial register port: mode 0, MSB first, 8-bit command then 24-bit data
`timescale 1ns/1ns
`default_nettype none
`include "self_cal_cfg.svh"
module cal_serial_port
  #(parameter int DATA_W = `CAL_WIDTH)
  (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  output logic [`SPI_ADDR_BITS-1:0] addr_o,
  output logic                   rd_start_o,
  input  wire logic [DATA_W-1:0] rd_data_i,
  output logic                   wr_o,
  output logic [DATA_W-1:0]      wr_data_o
  );
  localparam int CNT_W = 6;
  logic             sclk_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0]       cmd_reg;
  logic [DATA_W-1:0] shin_reg;
  logic [DATA_W-1:0] shout_reg;
  wire              rise  = sclk_i & ~sclk_reg;
  wire              fall  = ~sclk_i & sclk_reg;
  wire              cmd_done = rise && (cnt_reg == CNT_W'(`SPI_CMD_BITS - 1));
  wire              frame_done = rise && (cnt_reg == CNT_W'(`SPI_FRAME_BITS - 1));
  wire [7:0]        cmd_next = {cmd_reg[6:0], sdi_i};
  if (DATA_W != `CAL_WIDTH || `SPI_FRAME_BITS != `SPI_CMD_BITS + DATA_W)
  begin : g_frame_check
    $error("cal_serial_port: frame must be a command byte plus one register");
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cs_n_i)
    begin
      sclk_reg   <= 1'b0;
      cnt_reg    <= '0;
      cmd_reg    <= 8'h00;
      shin_reg   <= '0;
      shout_reg  <= '0;
      sdo_o      <= 1'b0;
      rd_start_o <= 1'b0;
      wr_o       <= 1'b0;
      addr_o     <= '0;
      wr_data_o  <= '0;
    end
    else
    begin
      sclk_reg   <= sclk_i;
      rd_start_o <= cmd_done && cmd_next[`SPI_CMD_RD_BIT];
      wr_o       <= frame_done && !cmd_reg[`SPI_CMD_RD_BIT];
      if (rise)
      begin
        cnt_reg <= cnt_reg + CNT_W'(1);
        if (cnt_reg < CNT_W'(`SPI_CMD_BITS))
          cmd_reg <= cmd_next;
        else
          shin_reg <= {shin_reg[DATA_W-2:0], sdi_i};
      end
      if (cmd_done)
        addr_o <= cmd_next[`SPI_ADDR_BITS-1:0];
      if (frame_done)
        wr_data_o <= {shin_reg[DATA_W-2:0], sdi_i};
      if (rd_start_o)
      begin
        shout_reg <= {rd_data_i[DATA_W-2:0], 1'b0};
        sdo_o     <= rd_data_i[DATA_W-1];
      end
      else if (fall && cnt_reg > CNT_W'(`SPI_CMD_BITS))
      begin
        sdo_o     <= shout_reg[DATA_W-1];
        shout_reg <= {shout_reg[DATA_W-2:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

/* File: self_cal_chk.sv */
// Checker for the correction pipeline and serial read output
`timescale 1ns/1ns
`default_nettype none
`include "self_cal_cfg.svh"
module self_cal_chk
  #(parameter int DATA_W = `CAL_WIDTH)
  (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cs_n_i,
  input wire logic              sclk_i,
  input wire logic              sdo_o,
  input wire logic              unipolar_i,
  input wire logic              raw_valid_i,
  input wire logic              out_valid_o,
  input wire logic [DATA_W-1:0] out_data_o,
  input wire logic              out_unipolar_o
  );
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_lat; $rose(raw_valid_i) |-> ##3 out_valid_o; endproperty
  a_lat: assert property (p_lat)
    else $error("no result three cycles after a sample");
  property p_src; out_valid_o |-> $past(raw_valid_i, 3); endproperty
  a_src: assert property (p_src)
    else $error("result without a sample");
  property p_gap; out_valid_o |=> !out_valid_o ##1 !out_valid_o; endproperty
  a_gap: assert property (p_gap)
    else $error("result pulse too long");
  property p_drop; raw_valid_i && $past(raw_valid_i) |-> ##3 !out_valid_o; endproperty
  a_drop: assert property (p_drop)
    else $error("crowded sample not dropped");
  property p_uni; out_valid_o |-> out_unipolar_o == $past(unipolar_i, 3); endproperty
  a_uni: assert property (p_uni)
    else $error("unipolar flag lost");
  property p_hold; !out_valid_o |-> $stable(out_data_o); endproperty
  a_hold: assert property (p_hold)
    else $error("result changed without valid");
  property p_idle; cs_n_i [*5] |-> $stable(sdo_o); endproperty
  a_idle: assert property (p_idle)
    else $error("serial output moved while deselected");
  property p_low; (!sclk_i && !cs_n_i) [*5] |-> $stable(sdo_o); endproperty
  a_low: assert property (p_low)
    else $error("serial output moved late in low phase");
endmodule
bind self_cal_correct self_cal_chk #(.DATA_W(DATA_W)) u_self_cal_chk (.clk_i(clk_i),
  .rst_i(rst_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .sdo_o(sdo_o), .unipolar_i(unipolar_i),
  .raw_valid_i(raw_valid_i), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
  .out_unipolar_o(out_unipolar_o));
`default_nettype wire

/* File: cal_host.sv */
// Host model: serial frames, mode 0, eight clocks per half period
`timescale 1ns/1ns
`default_nettype none
module cal_host
  (
  input  wire logic clk_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
  );
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  // Command byte then 24 data bits, both MSB first; clock idles low
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] f;
    f = {cmd, wd};
    rd = 24'h000000;
    @(posedge clk_i) cs_n_o <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      sdi_o <= f[i];
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b1;
      rd = {rd[22:0], sdo_i};
      repeat (8) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Testbench: register access over the serial port and corrected results
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, rst, cs_n, sclk, sdi, sdo, busy, load, uni, rv, ov, ou;
  logic [23:0] coff, cgain, raw, od;
  int err_count, n_compared;
  self_cal_correct u_self_cal_correct (.clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk),
    .sdi_i(sdi), .sdo_o(sdo), .cal_busy_i(busy), .cal_load_i(load), .cal_offset_i(coff),
    .cal_gain_i(cgain), .unipolar_i(uni), .raw_valid_i(rv), .raw_data_i(raw),
    .out_valid_o(ov), .out_data_o(od), .out_unipolar_o(ou));
  cal_host u_cal_host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task test_done;
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [1:0] idx, input logic [23:0] v);
    logic [23:0] d;
    u_cal_host.xfer({6'h00, idx}, v, d);
  endtask
  task rd(input logic [1:0] idx, input logic [23:0] exp);
    logic [23:0] d;
    u_cal_host.xfer({6'h20, idx}, 24'h5A5A5A, d);
    chk(d, exp);
  endtask
  // Sample held len cycles; only its first cycle may be taken
  task conv(input logic [23:0] r, input logic u, input int len, input logic [23:0] exp);
    int n;
    n = 0;
    @(posedge clk)
    begin
      raw <= r;
      uni <= u;
      rv <= 1'b1;
    end
    repeat (len) @(posedge clk);
    rv <= 1'b0;
    while (n < 20)
    begin
      @(negedge clk);
      if (ov === 1'b1)
        break;
      n++;
    end
    if (n == 20)
    begin
      err_count++;
      test_done();
    end
    else
    begin
      chk(od, exp);
      chk({23'h0, ou}, {23'h0, u});
    end
  endtask
  initial
  begin
    {rst, busy, load, uni, rv} = 5'h10;
    {coff, cgain, raw} = 72'h0;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 24'h000000);
    rd(2'h1, 24'h400000);
    rd(2'h3, 24'h000000);
    wr(2'h0, 24'h123456);
    rd(2'h0, 24'h123456);
    wr(2'h0, 24'hFFFFF0);
    wr(2'h1, 24'h600000);
    rd(2'h1, 24'h600000);
    conv(24'h000100, 1'b0, 1, 24'h000198);
    conv(24'h000100, 1'b1, 2, 24'h000198);
    wr(2'h2, 24'h000001);
    conv(24'h000100, 1'b0, 1, 24'h000180);
    wr(2'h2, 24'h000003);
    rd(2'h2, 24'h000003);
    conv(24'h000100, 1'b0, 1, 24'h000100);
    wr(2'h2, 24'h000002);
    conv(24'h000100, 1'b0, 1, 24'h000110);
    wr(2'h2, 24'h000000);
    wr(2'h0, 24'h000010);
    conv(24'h7FFFF0, 1'b0, 1, 24'h7FFFFF);
    conv(24'h800005, 1'b0, 1, 24'h800000);
    wr(2'h1, 24'h7FFFFF);
    conv(24'h000110, 1'b0, 1, 24'h000200);
    @(posedge clk) busy <= 1'b1;
    wr(2'h1, 24'h400000);
    busy <= 1'b0;
    rd(2'h1, 24'h7FFFFF);
    @(posedge clk)
    begin
      {coff, cgain} <= 48'h000020_400000;
      load <= 1'b1;
    end
    @(posedge clk) load <= 1'b0;
    rd(2'h0, 24'h000020);
    rd(2'h1, 24'h400000);
    test_done();
  end
endmodule
`default_nettype wire
